/* File: src/drsc_defs.svh */
// Function
// (RULE_01) The 14-bit tick interval counts clock cycles and yields one refresh tick each time it elapses.
// (RULE_02) Software programs the interval to 0xc30, 0x104b or 0x1450 by memory clock; 0xc30 is the reset value.
// (RULE_03) Refresh-on at bit 23 enables refresh when 1 and disables it when 0, resetting to 0.
// (RULE_04) With refresh off and owed-count-run at bit 25 set, owed refreshes accumulate but none are issued.
// (RULE_05) With refresh on, owed-count-run has no effect and the owed counter always runs.
// (RULE_06) Rank-refresh-style at bit 24 selects staggered all-rank refresh (0) or independent per-rank refresh (1).
// (RULE_07) An owed count above the urgent level (bits 19:18, levels 5 to 8) requests refresh and sets the urgent flag.
// (RULE_08) An owed count above the upper level (bits 17:16, levels 3 to 6) requests refresh and sets the upper flag.
// (RULE_09) An owed count above the lower level (bits 15:14, levels 1 to 4) requests refresh and sets the lower flag.
// (RULE_10) In independent-rank mode a calibration request waits the direct quiet window in ticks, reset 5'b10000.
// (RULE_11) In independent-rank mode a calibration request waits the indirect quiet window in ticks, reset 5'b11000.
// (RULE_12) In independent-rank mode a calibration request waits the calibration wait in ticks, reset 5'b00110.
// (RULE_13) Software writes memory-init-complete at bit 22 when memory init is done; it is read/write, reset 0.
// (RULE_14) The owed counter rises on each allowed tick and falls on each completed refresh, never below zero.
// (RULE_15) Reserved bits 47:42, 26 and 21:20 read as zero and ignore writes.
`ifndef DRSC_DEFS_SVH
`define DRSC_DEFS_SVH
`define DRSC_CTRL_IDX 12'h669
// Byte address is four times the index, so it needs more than 12 address bits
`define DRSC_CTRL_LO_ADDR 16'h19a4
`define DRSC_CTRL_HI_ADDR 16'h19a8
`define DRSC_STAT_ADDR 16'h19ac
`define DRSC_MASK_ADDR 16'h19b0
`define DRSC_CTRL_RESET 48'h021830000c30
`define DRSC_CTRL_WMASK 48'h03fffbcfffff
`define DRSC_INTERVAL_MSB 13
`define DRSC_LOW_LSB 14
`define DRSC_UPPER_LSB 16
`define DRSC_URGENT_LSB 18
`define DRSC_INIT_BIT 22
`define DRSC_REF_ON_BIT 23
`define DRSC_RANK_STYLE_BIT 24
`define DRSC_COUNT_RUN_BIT 25
`define DRSC_WAIT_LSB 27
`define DRSC_INDIR_LSB 32
`define DRSC_DIR_LSB 37
`define DRSC_LOW_BASE 4'h1
`define DRSC_UPPER_BASE 4'h3
`define DRSC_URGENT_BASE 4'h5
`define DRSC_OWED_MAX 4'hf
`define DRSC_PERIOD_NS 7800
`define DRSC_CLK_PERIOD_NS 10
`endif

/* File: src/drsc_pkg.sv */
package drsc_pkg;
  typedef enum logic [1:0] {
    DRSC_CAL_IDLE = 2'b00,
    DRSC_CAL_WAIT = 2'b01,
    DRSC_CAL_GRANT = 2'b10
  } drsc_cal_state_type;
endpackage

/* File: src/drsc_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drsc_defs.svh"
module drsc_tick_gen (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [13:0] interval,
  output logic tick
);
  logic [13:0] count_r;
  logic [13:0] count_nxt;
  wire elapsed = (count_r >= interval - 14'h0001) || (interval == 14'h0000);
  assign count_nxt = elapsed ? 14'h0000 : count_r + 14'h0001;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= 14'h0000;
      tick <= 1'b0;
    end else begin
      count_r <= count_nxt; // RULE_01
      tick <= elapsed; // RULE_01
    end
  end
  gap_tick_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_01
    tick && interval > 14'h0002 && $stable(interval) |=> !tick)
    else $error("Ticks too close");
endmodule
`default_nettype wire

/* File: src/drsc_cal_gate.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drsc_defs.svh"
module drsc_cal_gate (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic independent,
  input wire logic cal_req,
  input wire logic [4:0] wait_ticks,
  output logic cal_grant
);
  drsc_pkg::drsc_cal_state_type state_r;
  drsc_pkg::drsc_cal_state_type state_nxt;
  logic [4:0] left_r;
  logic [4:0] left_nxt;
  wire done = (left_r == 5'h00);
  always_comb begin
    state_nxt = state_r;
    left_nxt = left_r;
    unique case (state_r)
      drsc_pkg::DRSC_CAL_IDLE: begin
        if (cal_req) begin
          left_nxt = independent ? wait_ticks : 5'h00; // RULE_10 RULE_11 RULE_12
          state_nxt = drsc_pkg::DRSC_CAL_WAIT;
        end
      end
      drsc_pkg::DRSC_CAL_WAIT: begin
        if (done) begin
          state_nxt = drsc_pkg::DRSC_CAL_GRANT;
        end else if (tick) begin
          left_nxt = left_r - 5'h01;
        end
      end
      drsc_pkg::DRSC_CAL_GRANT: begin
        state_nxt = drsc_pkg::DRSC_CAL_IDLE;
      end
      default: begin
        state_nxt = drsc_pkg::DRSC_CAL_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= drsc_pkg::DRSC_CAL_IDLE;
      left_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      left_r <= left_nxt;
    end
  end
  assign cal_grant = (state_r == drsc_pkg::DRSC_CAL_GRANT);
  grant_after_wait_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_10
    state_r == drsc_pkg::DRSC_CAL_WAIT && !done |=> !cal_grant)
    else $error("Grant before quiet window");
endmodule
`default_nettype wire

/* File: src/drsc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drsc_defs.svh"
module drsc_top (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REFRESH_DONE,
  input wire logic CAL_REQ,
  output logic REFRESH_REQ,
  output logic ALL_RANK,
  output logic FLAG_LOW,
  output logic FLAG_UPPER,
  output logic FLAG_URGENT,
  output logic CAL_GRANT,
  output logic INIT_COMPLETE,
  output logic IRQ
);
  // Interval also derivable from time: period / clock period
  localparam int DRSC_TICK_CYCLES = `DRSC_PERIOD_NS / `DRSC_CLK_PERIOD_NS;
  logic [47:0] ctrl_r;
  logic [47:0] ctrl_nxt;
  logic [3:0] owed_r;
  logic [3:0] owed_nxt;
  logic [2:0] stat_r;
  logic [2:0] stat_nxt;
  logic [2:0] mask_r;
  logic [1:0] cal_sync_r;
  logic [1:0] done_sync_r;
  logic tick;
  logic cal_grant;
  // Both scheduler inputs cross from another block's clock: two stages
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cal_sync_r <= 2'h0;
      done_sync_r <= 2'h0;
    end else begin
      cal_sync_r <= {cal_sync_r[0], CAL_REQ};
      done_sync_r <= {done_sync_r[0], REFRESH_DONE};
    end
  end
  wire cal_req_s = cal_sync_r[1];
  wire done_s = done_sync_r[1];
  // Done taken as a level; one refresh per synced high cycle
  wire ref_on = ctrl_r[`DRSC_REF_ON_BIT];
  wire count_run = ctrl_r[`DRSC_COUNT_RUN_BIT];
  wire independent = ctrl_r[`DRSC_RANK_STYLE_BIT];
  wire counting = ref_on | count_run; // RULE_04 RULE_05
  wire [3:0] low_lvl = `DRSC_LOW_BASE + {2'h0, ctrl_r[`DRSC_LOW_LSB +: 2]}; // RULE_09
  wire [3:0] upper_lvl = `DRSC_UPPER_BASE + {2'h0, ctrl_r[`DRSC_UPPER_LSB +: 2]}; // RULE_08
  wire [3:0] urgent_lvl = `DRSC_URGENT_BASE + {2'h0, ctrl_r[`DRSC_URGENT_LSB +: 2]}; // RULE_07
  wire over_low = owed_r > low_lvl;
  wire over_upper = owed_r > upper_lvl;
  wire over_urgent = owed_r > urgent_lvl;
  wire inc = tick && counting && (owed_r != `DRSC_OWED_MAX);
  wire dec = done_s && (owed_r != 4'h0);
  always_comb begin
    owed_nxt = owed_r;
    if (!counting) begin
      owed_nxt = 4'h0;
    end else if (inc && !dec) begin
      owed_nxt = owed_r + 4'h1; // RULE_14
    end else if (dec && !inc) begin
      owed_nxt = owed_r - 4'h1; // RULE_14
    end
  end
  // APB: zero wait states, reply in the access cycle
  wire setup = PSEL && !PENABLE;
  wire wr_en = PSEL && PENABLE && PWRITE;
  wire rd_en = PSEL && PENABLE && !PWRITE;
  wire hit_lo = (PADDR == `DRSC_CTRL_LO_ADDR);
  wire hit_hi = (PADDR == `DRSC_CTRL_HI_ADDR);
  wire hit_stat = (PADDR == `DRSC_STAT_ADDR);
  wire hit_mask = (PADDR == `DRSC_MASK_ADDR);
  wire mapped = hit_lo | hit_hi | hit_stat | hit_mask;
  wire [47:0] wmask = `DRSC_CTRL_WMASK;
  wire [47:0] wr_val = hit_lo ? {ctrl_r[47:32], PWDATA} : {PWDATA[15:0], ctrl_r[31:0]};
  assign ctrl_nxt = (wr_en && (hit_lo || hit_hi)) ?
                    (wr_val & wmask) : ctrl_r; // RULE_15 RULE_13
  wire [2:0] events = {over_urgent, over_upper, over_low};
  assign stat_nxt = ((rd_en && hit_stat) ? 3'h0 : stat_r) | events;
  wire [31:0] rd_mux = hit_lo ? ctrl_r[31:0] :
                       hit_hi ? {16'h0000, ctrl_r[47:32]} :
                       hit_stat ? {29'h0, stat_r} :
                       hit_mask ? {29'h0, mask_r} : 32'h0;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_r <= `DRSC_CTRL_RESET; // RULE_02 RULE_03
      mask_r <= 3'h0;
      stat_r <= 3'h0;
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_en && hit_mask) begin
        mask_r <= PWDATA[2:0];
      end
      stat_r <= stat_nxt;
      PREADY <= setup;
      PSLVERR <= setup && !mapped;
      PRDATA <= (setup && !PWRITE) ? rd_mux : 32'h0;
    end
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      owed_r <= 4'h0;
      REFRESH_REQ <= 1'b0;
      FLAG_LOW <= 1'b0;
      FLAG_UPPER <= 1'b0;
      FLAG_URGENT <= 1'b0;
      ALL_RANK <= 1'b1;
      CAL_GRANT <= 1'b0;
      INIT_COMPLETE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      owed_r <= owed_nxt;
      // Any crossed level asks, since upper may sit below lower
      REFRESH_REQ <= ref_on && |events; // RULE_03 RULE_04 RULE_07 RULE_08 RULE_09
      FLAG_LOW <= over_low; // RULE_09
      FLAG_UPPER <= over_upper; // RULE_08
      FLAG_URGENT <= over_urgent; // RULE_07
      ALL_RANK <= !independent; // RULE_06
      CAL_GRANT <= cal_grant;
      INIT_COMPLETE <= ctrl_r[`DRSC_INIT_BIT];
      IRQ <= |(stat_nxt & mask_r);
    end
  end
  drsc_tick_gen u_tick (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .interval(ctrl_r[`DRSC_INTERVAL_MSB:0]),
    .tick(tick)
  );
  // Longest window picked so both direct and indirect paths stay quiet
  wire [4:0] w_dir = ctrl_r[`DRSC_DIR_LSB +: 5];
  wire [4:0] w_ind = ctrl_r[`DRSC_INDIR_LSB +: 5];
  wire [4:0] w_cal = ctrl_r[`DRSC_WAIT_LSB +: 5];
  wire [4:0] w_di = (w_dir > w_ind) ? w_dir : w_ind;
  wire [4:0] w_max = (w_di > w_cal) ? w_di : w_cal; // RULE_10 RULE_11 RULE_12
  drsc_cal_gate u_cal (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .tick(tick),
    .independent(independent),
    .cal_req(cal_req_s),
    .wait_ticks(w_max),
    .cal_grant(cal_grant)
  );
  sequence owed_over_low_s;
    ref_on && over_low;
  endsequence
  req_follow_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_09
    owed_over_low_s |=> REFRESH_REQ)
    else $error("Refresh request missing");
  req_upper_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_08
    ref_on && (over_upper || over_urgent) |=> REFRESH_REQ)
    else $error("Refresh request missing above upper level");
  no_req_off_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_03
    !ref_on |=> !REFRESH_REQ)
    else $error("Request while refresh off");
  urgent_flag_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_07
    (owed_r > urgent_lvl) |=> FLAG_URGENT)
    else $error("Urgent flag missing");
  upper_flag_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_08
    FLAG_UPPER |-> $past(owed_r) > $past(upper_lvl))
    else $error("Upper flag without cause");
  owed_inc_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_14
    inc && !dec |=> owed_r == $past(owed_r) + 4'h1)
    else $error("Owed count did not rise");
  owed_hold_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_04
    !counting |=> owed_r == 4'h0)
    else $error("Owed count ran while stopped");
  run_ignored_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_05
    ref_on && tick && !done_s && owed_r < 4'hf |=> owed_r == $past(owed_r) + 4'h1)
    else $error("Counter stopped while refresh on");
  reserved_zero_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_15
    ctrl_r[47:42] == 6'h0 && !ctrl_r[26] && ctrl_r[21:20] == 2'h0)
    else $error("Reserved bit set");
  style_out_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_06
    $changed(independent) |=> ALL_RANK == !$past(independent))
    else $error("Rank style not followed");
  init_out_a: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE_13
    ##1 INIT_COMPLETE == $past(ctrl_r[`DRSC_INIT_BIT]))
    else $error("Init flag not mirrored");
endmodule
`default_nettype wire

/* File: bench/drsc_sched_model.sv */
`timescale 1ns/1ps
`default_nettype none
module drsc_sched_model #(
  parameter int DELAY = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic refresh_req,
  output logic refresh_done
);
  // One completion every DELAY+1 cycles while asked; en low stops the scheduler and clears its count
  int cnt;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      refresh_done <= 1'h0;
    end else begin
      refresh_done <= en && refresh_req && cnt == DELAY;
      cnt <= (en && refresh_req && cnt < DELAY) ? cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

/* File: bench/test_dram_refresh_scheduler_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drsc_defs.svh"
module test_dram_refresh_scheduler_ctrl;
  localparam int IV = 20;
  logic clk, arst_n, psel, pen, pwr, done, cal, en, e;
  logic pready, perr, req, all_rank, fl, fu, fg, grant, init, irq;
  logic [15:0] pa;
  logic [31:0] pwd, prd, q, tl, tu, tg;
  logic [31:0] cyc = 32'h0;
  int mismatches, checked, n;
  drsc_top dut_u (.REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr),
    .REFRESH_DONE(done), .CAL_REQ(cal), .REFRESH_REQ(req), .ALL_RANK(all_rank),
    .FLAG_LOW(fl), .FLAG_UPPER(fu), .FLAG_URGENT(fg), .CAL_GRANT(grant),
    .INIT_COMPLETE(init), .IRQ(irq));
  drsc_sched_model #(.DELAY(4)) sched_u (.clk(clk), .arst_n(arst_n), .en(en),
    .refresh_req(req), .refresh_done(done));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Flag rise times sampled before the edge updates land, so all three agree
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (fl === 1'h1 && tl == 0) tl <= cyc;
    if (fu === 1'h1 && tu == 0) tu <= cyc;
    if (fg === 1'h1 && tg == 0) tg <= cyc;
    if (cyc == 32'd60000) begin
      mismatches++;
      summarize();
    end
  end
  task summarize();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1; pen <= 1'h0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    q = prd;
    e = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task lo(input logic [31:0] d);
    apb(1'h1, `DRSC_CTRL_LO_ADDR, d);
  endtask
  task rd(input logic [15:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  // m is {count run, rank style, refresh on, init complete}, lv is {urgent, upper, lower}
  function automatic logic [31:0] cw(input logic [3:0] m, input logic [5:0] lv,
    input logic [4:0] w);
    return {w, 1'h0, m, 2'h0, lv, 14'(IV)};
  endfunction
  task wait_for(input int lim);
    n = 0;
    while (n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task t_regs();
    chk("all_rank", all_rank, 32'h1);
    rd(`DRSC_CTRL_LO_ADDR); chk("ctrl_lo", q, 32'h30000c30);
    rd(`DRSC_CTRL_HI_ADDR); chk("ctrl_hi", q, 32'h218);
    chk("init", init, 32'h0);
    lo(32'hffffffff);
    apb(1'h1, `DRSC_CTRL_HI_ADDR, 32'hffffffff);
    rd(`DRSC_CTRL_LO_ADDR); chk("lo_rsv", q, 32'hfbcfffff);
    rd(`DRSC_CTRL_HI_ADDR); chk("hi_rsv", q, 32'h3ff);
    chk("init_set", init, 32'h1);
    chk("style", all_rank, 32'h0);
    rd(16'h0000); chk("unmapped", {e, q[30:0]}, 32'h80000000);
    apb(1'h1, `DRSC_CTRL_HI_ADDR, 32'h218);
  endtask
  task t_levels();
    for (int c = 0; c < 4; c++) begin
      lo(cw(4'h0, 6'h0, 5'h0));
      repeat (10) @(posedge clk);
      chk("stop_clear", fl, 32'h0);
      tl = 0; tu = 0; tg = 0;
      lo(cw(4'h8, {2'(3 - c), 2'(3 - c), 2'(c)}, 5'h0));
      n = 0;
      while (fg !== 1'h1 && n < 400) begin @(posedge clk); n++; end
      // Let the flag time stamps land before reading them
      @(posedge clk);
      chk("req_off", req, 32'h0);
      chk("upper_gap", tu - tl, (5 - 2 * c) * IV);
      chk("urgent_gap", tg - tl, (7 - 2 * c) * IV);
    end
  endtask
  task t_irq();
    apb(1'h1, `DRSC_MASK_ADDR, 32'h0); repeat (3) @(posedge clk);
    chk("irq_masked", irq, 32'h0);
    apb(1'h1, `DRSC_MASK_ADDR, 32'h7); repeat (3) @(posedge clk);
    chk("irq_on", irq, 32'h1);
    rd(`DRSC_STAT_ADDR); chk("status", q, 32'h7);
    lo(cw(4'h0, 6'h0, 5'h0)); repeat (10) @(posedge clk);
    rd(`DRSC_STAT_ADDR); rd(`DRSC_STAT_ADDR); chk("status_clr", q, 32'h0);
    wait_for(12 * IV);
    chk("off_flag", fl, 32'h0);
    chk("irq_off", irq, 32'h0);
  endtask
  task t_upper_req();
    lo(cw(4'h2, {2'h3, 2'h0, 2'h3}, 5'h0));
    n = 0;
    while (fu !== 1'h1 && n < 400) begin @(posedge clk); n++; end
    chk("upper_only", fl, 32'h0);
    chk("upper_req", req, 32'h1);
    lo(cw(4'h0, 6'h0, 5'h0));
  endtask
  task t_refresh();
    lo(cw(4'h2, 6'h0, 5'h0));
    n = 0;
    while (fg !== 1'h1 && n < 400) begin @(posedge clk); n++; end
    chk("run_on", fg, 32'h1);
    chk("req_on", req, 32'h1);
    en <= 1'h1;
    n = 0;
    while (req !== 1'h0 && n < 600) begin @(posedge clk); n++; end
    chk("drained", fg, 32'h0);
    en <= 1'h0;
    lo(cw(4'h0, 6'h0, 5'h0));
  endtask
  task t_cal();
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        apb(1'h1, `DRSC_CTRL_HI_ADDR, 32'h41);
        lo(cw(4'h4, 6'h0, 5'h3));
      end
      cal <= 1'h1;
      n = 0;
      while (grant !== 1'h1 && n < 400) begin @(posedge clk); n++; end
      cal <= 1'h0;
      if (s == 0) chk("cal_shared", n <= 10, 32'h1);
      else chk("cal_quiet", n >= 2 * IV && n <= 3 * IV + 12, 32'h1);
      repeat (30) @(posedge clk);
    end
  endtask
  initial begin
    arst_n = 1'h0; psel = 1'h0; pen = 1'h0; pwr = 1'h0; pa = 16'h0000; pwd = 32'h0;
    cal = 1'h0; en = 1'h0; mismatches = 0; checked = 0; tl = 0; tu = 0; tg = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'h1;
    t_regs();
    t_levels();
    t_irq();
    t_upper_req();
    t_refresh();
    t_cal();
    summarize();
  end
endmodule
`default_nettype wire
